// File: ssm_pkg.sv
// Function
// - Sync, slave clock, port enabled gives slave
// - Slave transmits when both receive enables clear
// - Port enable off resets port and overrun
// - Slave transmit works like master transmit
// - First written character loads shifter at once
// - Second character waits, transmit flag stays clear
// - After shift-out, load held character, set flag
// - Transmit flag in sleep raises wake request
// - Slave receive runs continuously, single enable alone acts like continuous
// - Completed character moves to data, may wake
// - Receive flag on completion, interrupt if enabled
// - Overrun cleared when both receive enables are clear, by a data read with only single enable set, or by port off
// - Ninth bit and errors in receive status
// - Master receive starts on single or continuous
// - Master shift clock from divisor settings
// - Nine-bit transmit sends ninth bit plus byte
// - Slave transmit also needs transmit enable
// - Only slave mode runs during sleep
// - Unimplemented bits read as zero
// - Sample on trailing edge, change on leading
// - Two-character buffer, third sets overrun, no overwrite
// - Master single receive clears itself after character
// - Polarity selects idle level and change edge
package ssm_pkg;

typedef enum logic [1:0] {
	TXS_IDLE = 2'b01,
	TXS_SHIFT = 2'b10
} ssm_txs_e;

localparam logic [3:0] ADR_BAUD = 4'h0;
localparam logic [3:0] ADR_INTC = 4'h1;
localparam logic [3:0] ADR_PIE = 4'h2;
localparam logic [3:0] ADR_PIR = 4'h3;
localparam logic [3:0] ADR_RXD = 4'h4;
localparam logic [3:0] ADR_RCST = 4'h5;
localparam logic [3:0] ADR_DIVL = 4'h6;
localparam logic [3:0] ADR_DIVH = 4'h7;
localparam logic [3:0] ADR_TXST = 4'h8;
localparam logic [3:0] ADR_TXD = 4'h9;

localparam int BIT_POL = 4;
localparam int BIT_WIDE = 3;
localparam int BIT_GLOB_IE = 7;
localparam int BIT_PERI_IE = 6;
localparam int BIT_RX_IE = 5;
localparam int BIT_TX_IE = 4;
localparam int BIT_RX_FLAG = 5;
localparam int BIT_TX_FLAG = 4;
localparam int BIT_PORT_EN = 7;
localparam int BIT_RX_NINE = 6;
localparam int BIT_RX_ONE = 5;
localparam int BIT_RX_CONT = 4;
localparam int BIT_OVERRUN = 1;
localparam int BIT_RX_BIT8 = 0;
localparam int BIT_CLK_MST = 7;
localparam int BIT_TX_NINE = 6;
localparam int BIT_TX_EN = 5;
localparam int BIT_SYNC = 4;
localparam int BIT_HI_RATE = 2;
localparam int BIT_TX_IDLE = 1;
localparam int BIT_TX_BIT8 = 0;

localparam logic [7:0] REG_RST = 8'h00;
localparam logic [8:0] CHAR_RST = 9'h000;
localparam logic [3:0] CNT_RST = 4'h0;
localparam logic [3:0] CNT8 = 4'h8;
localparam logic [3:0] CNT9 = 4'h9;
localparam logic [1:0] FIFO_EMPTY = 2'h0;
localparam logic [1:0] FIFO_FULL = 2'h2;
localparam logic [15:0] DIV_ZERO = 16'h0000;

function automatic logic [3:0] ssm_nbits(input logic nine);
	return nine ? CNT9 : CNT8;
endfunction

endpackage

// File: ssm_brg.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_brg
	import ssm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic wide,
	input wire logic [15:0] divisor,
	// Half-period strobe
	output logic tick
);

logic [15:0] cnt;

// One tick every divisor+1 cycles; narrow mode uses the low byte only
always_ff @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		cnt <= DIV_ZERO;
		tick <= 1'b0;
	end else if (!run) begin
		cnt <= DIV_ZERO;
		tick <= 1'b0;
	end else if (cnt == DIV_ZERO) begin
		cnt <= wide ? divisor : {REG_RST, divisor[7:0]};
		tick <= 1'b1;
	end else begin
		cnt <= cnt - 16'h0001;
		tick <= 1'b0;
	end
end

endmodule
`default_nettype wire

// File: ssm_port.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_port
	import ssm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Power state and requests
	input wire logic sleep_mode,
	output logic wake_req,
	output logic irq_req,
	// Shift clock pin
	input wire logic shift_clock_pin_in,
	output logic shift_clock_pin_out,
	output logic shift_clock_pin_oe_n,
	// Data pin
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe_n
);

logic clock_polarity_select, wide_divisor_select;
logic global_interrupt_enable, peripheral_interrupt_enable;
logic receive_interrupt_enable, transmit_interrupt_enable;
logic serial_port_enable, nine_bit_receive;
logic single_receive_enable, continuous_receive_enable;
logic clock_source_master, nine_bit_transmit, transmit_enable;
logic sync_mode, high_rate_select, transmit_ninth_bit;
logic [7:0] divisor_low_byte, divisor_high_byte;
logic ck_s1, ck_s2, ck_s3, dt_s1, dt_s2;
logic port_on, is_master, is_slave, rx_mode, tx_mode;
logic tx_run, rx_run, m_work, ck_idle, brg_tick;
logic ck_rise, ck_fall, lead_e, trail_e;
ssm_txs_e tx_state;
logic [8:0] transmit_holding_register, transmit_shift_register;
logic thr_full;
logic [3:0] tcnt, rcnt;
logic [8:0] receive_shift_register, next_rsr, top_char;
logic [8:0] rx_fifo [0:1];
logic fifo_head, overrun_error;
logic [1:0] fifo_cnt;
logic rx_last, rx_done, rx_push, rx_pop, single_done;
logic receive_flag, transmit_flag, int_src, tx_wr;
logic [7:0] rd_val;

default clocking cb @(posedge ref_clk); endclocking
default disable iff (rst);

// Pin synchronisers
always_ff @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		ck_s1 <= 1'b0;
		ck_s2 <= 1'b0;
		ck_s3 <= 1'b0;
		dt_s1 <= 1'b0;
		dt_s2 <= 1'b0;
	end else begin
		ck_s1 <= shift_clock_pin_in;
		ck_s2 <= ck_s1;
		ck_s3 <= ck_s2;
		dt_s1 <= serial_data_pin_in;
		dt_s2 <= dt_s1;
	end
end

// Control registers
always_ff @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		clock_polarity_select <= 1'b0;
		wide_divisor_select <= 1'b0;
		global_interrupt_enable <= 1'b0;
		peripheral_interrupt_enable <= 1'b0;
		receive_interrupt_enable <= 1'b0;
		transmit_interrupt_enable <= 1'b0;
		serial_port_enable <= 1'b0;
		nine_bit_receive <= 1'b0;
		continuous_receive_enable <= 1'b0;
		clock_source_master <= 1'b0;
		nine_bit_transmit <= 1'b0;
		transmit_enable <= 1'b0;
		sync_mode <= 1'b0;
		high_rate_select <= 1'b0;
		transmit_ninth_bit <= 1'b0;
		divisor_low_byte <= REG_RST;
		divisor_high_byte <= REG_RST;
	end else if (wr) begin
		case (addr)
			ADR_BAUD: begin
				clock_polarity_select <= wdata[BIT_POL];
				wide_divisor_select <= wdata[BIT_WIDE];
			end
			ADR_INTC: begin
				global_interrupt_enable <= wdata[BIT_GLOB_IE];
				peripheral_interrupt_enable <= wdata[BIT_PERI_IE];
			end
			ADR_PIE: begin
				receive_interrupt_enable <= wdata[BIT_RX_IE];
				transmit_interrupt_enable <= wdata[BIT_TX_IE];
			end
			ADR_RCST: begin
				serial_port_enable <= wdata[BIT_PORT_EN];
				nine_bit_receive <= wdata[BIT_RX_NINE];
				continuous_receive_enable <= wdata[BIT_RX_CONT];
			end
			ADR_DIVL: divisor_low_byte <= wdata;
			ADR_DIVH: divisor_high_byte <= wdata;
			ADR_TXST: begin
				clock_source_master <= wdata[BIT_CLK_MST];
				nine_bit_transmit <= wdata[BIT_TX_NINE];
				transmit_enable <= wdata[BIT_TX_EN];
				sync_mode <= wdata[BIT_SYNC];
				high_rate_select <= wdata[BIT_HI_RATE];
				transmit_ninth_bit <= wdata[BIT_TX_BIT8];
			end
			default: ;
		endcase
	end
end

// Single receive: software sets, hardware clears after one character in master mode only
always_ff @(posedge ref_clk or posedge rst) begin
	if (rst)
		single_receive_enable <= 1'b0;
	else if (wr && addr == ADR_RCST)
		single_receive_enable <= wdata[BIT_RX_ONE];
	else if (single_done)
		single_receive_enable <= 1'b0;
end

// Mode decode
always_comb begin
	port_on = serial_port_enable & sync_mode;
	is_master = port_on & clock_source_master;
	is_slave = port_on & ~clock_source_master;
	rx_mode = single_receive_enable | continuous_receive_enable;
	tx_mode = port_on & ~rx_mode & transmit_enable;
	// Master logic stops with the system clock in sleep
	tx_run = tx_mode & (is_slave | ~sleep_mode);
	// Slave receive has no idle state while a receive enable is set and no overrun is flagged
	rx_run = port_on & rx_mode & ~overrun_error
		& (is_slave | ~sleep_mode);
	m_work = (tx_run & (tx_state == TXS_SHIFT)) | rx_run;
	ck_idle = shift_clock_pin_out == clock_polarity_select;
	ck_rise = ck_s2 & ~ck_s3;
	ck_fall = ~ck_s2 & ck_s3;
	if (is_master) begin
		lead_e = brg_tick & ck_idle & m_work;
		// Stray tick in the first sleep cycle must not shift
		trail_e = brg_tick & ~ck_idle & ~sleep_mode;
	end else begin
		lead_e = is_slave
			& (clock_polarity_select ? ck_fall : ck_rise);
		trail_e = is_slave
			& (clock_polarity_select ? ck_rise : ck_fall);
	end
end

ssm_brg u_brg (
	.ref_clk(ref_clk),
	.rst(rst),
	.run(is_master & ~sleep_mode),
	.wide(wide_divisor_select),
	.divisor({divisor_high_byte, divisor_low_byte}),
	.tick(brg_tick)
);

// Generated clock; parks at the idle level once no work remains
always_ff @(posedge ref_clk or posedge rst) begin
	if (rst)
		shift_clock_pin_out <= 1'b0;
	else if (!is_master)
		shift_clock_pin_out <= clock_polarity_select;
	else if (brg_tick && !sleep_mode && (!ck_idle || m_work))
		shift_clock_pin_out <= ~shift_clock_pin_out;
end

// Pin drivers; enables are active low
always_ff @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		shift_clock_pin_oe_n <= 1'b1;
		serial_data_pin_oe_n <= 1'b1;
	end else begin
		shift_clock_pin_oe_n <= ~is_master;
		serial_data_pin_oe_n <= ~tx_mode;
	end
end

a_slave_no_clk: assert property (is_slave |=> shift_clock_pin_oe_n)
	else $error("slave drives the clock pin");

// Transmit path
assign tx_wr = wr && addr == ADR_TXD;

always_ff @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		tx_state <= TXS_IDLE;
		thr_full <= 1'b0;
		transmit_holding_register <= CHAR_RST;
		transmit_shift_register <= CHAR_RST;
		tcnt <= CNT_RST;
	end else if (!port_on) begin
		tx_state <= TXS_IDLE;
		thr_full <= 1'b0;
		tcnt <= CNT_RST;
	end else begin
		case (tx_state)
			TXS_IDLE: begin
				if (tx_run && thr_full) begin
					transmit_shift_register <= transmit_holding_register;
					thr_full <= 1'b0;
					tcnt <= CNT_RST;
					tx_state <= TXS_SHIFT;
				end
			end
			TXS_SHIFT: begin
				if (!tx_mode)
					tx_state <= TXS_IDLE;
				else begin
					if (lead_e) begin
						transmit_shift_register <= transmit_shift_register >> 1;
						tcnt <= tcnt + 4'h1;
					end
					// Done only after the last bit's trailing edge
					if (trail_e && tcnt == ssm_nbits(nine_bit_transmit))
						tx_state <= TXS_IDLE;
				end
			end
			default: tx_state <= TXS_IDLE;
		endcase
		// Held character waits while the shifter is busy
		if (tx_wr) begin
			transmit_holding_register <= {transmit_ninth_bit, wdata};
			thr_full <= 1'b1;
		end
	end
end

always_ff @(posedge ref_clk or posedge rst) begin
	if (rst)
		serial_data_pin_out <= 1'b0;
	else if (tx_state == TXS_SHIFT && lead_e)
		serial_data_pin_out <= transmit_shift_register[0];
end

assign transmit_flag = ~thr_full;

a_hold_second: assert property (tx_state == TXS_SHIFT && thr_full
	&& port_on |=> thr_full)
	else $error("held character left the holding register");
a_load_next: assert property (tx_state == TXS_IDLE && thr_full && tx_run
	&& !tx_wr |=> tx_state == TXS_SHIFT && transmit_flag)
	else $error("held character not moved to the shifter");
a_bit_order: assert property (tx_state == TXS_SHIFT && lead_e
	|=> serial_data_pin_out == $past(transmit_shift_register[0]))
	else $error("wrong bit driven on the data pin");
c_tx_done: cover property (tx_state == TXS_SHIFT ##1 tx_state == TXS_IDLE);

// Receive path
always_comb begin
	next_rsr = receive_shift_register;
	next_rsr[rcnt] = dt_s2;
	if (!nine_bit_receive)
		next_rsr[8] = 1'b0;
	rx_last = rcnt == ssm_nbits(nine_bit_receive) - 4'h1;
	rx_done = rx_run & trail_e & rx_last;
	rx_push = rx_done & (fifo_cnt != FIFO_FULL);
	rx_pop = rd & (addr == ADR_RXD) & (fifo_cnt != FIFO_EMPTY);
	single_done = is_master & rx_done & ~continuous_receive_enable;
	receive_flag = fifo_cnt != FIFO_EMPTY;
	top_char = receive_flag ? rx_fifo[fifo_head] : CHAR_RST;
end

// Memory words carry no reset; validity lives in fifo_cnt
always_ff @(posedge ref_clk) begin
	if (rx_push && port_on)
		rx_fifo[fifo_head ^ fifo_cnt[0]] <= next_rsr;
end

always_ff @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		receive_shift_register <= CHAR_RST;
		rcnt <= CNT_RST;
		fifo_head <= 1'b0;
		fifo_cnt <= FIFO_EMPTY;
		overrun_error <= 1'b0;
	end else if (!port_on) begin
		rcnt <= CNT_RST;
		fifo_head <= 1'b0;
		fifo_cnt <= FIFO_EMPTY;
		overrun_error <= 1'b0;
	end else begin
		// Partial character is dropped when reception stops
		if (!rx_run)
			rcnt <= CNT_RST;
		else if (trail_e) begin
			receive_shift_register <= next_rsr;
			rcnt <= rx_last ? CNT_RST : rcnt + 4'h1;
		end
		if (rx_pop)
			fifo_head <= ~fifo_head;
		fifo_cnt <= fifo_cnt + {1'b0, rx_push} - {1'b0, rx_pop};
		if (rx_done && !rx_push)
			overrun_error <= 1'b1;
		else if (!continuous_receive_enable
			&& (!single_receive_enable || rx_pop))
			overrun_error <= 1'b0;
	end
end

a_ovr_set: assert property (rx_done && fifo_cnt == FIFO_FULL && !rx_pop
	|=> overrun_error && fifo_cnt == FIFO_FULL)
	else $error("third character did not raise overrun");
a_ovr_port: assert property (!serial_port_enable |=> !overrun_error)
	else $error("overrun survived port disable");
a_single_one: assert property (single_done && !wr
	|=> !single_receive_enable) else $error("single receive not cleared");
a_sleep_halt: assert property (sleep_mode && is_master
	|-> !lead_e && !trail_e) else $error("master shifted during sleep");
c_slave_rx: cover property (is_slave && rx_push);
c_overrun: cover property ($rose(overrun_error));

// Interrupt and wake requests
assign int_src = (receive_interrupt_enable & receive_flag)
	| (peripheral_interrupt_enable & transmit_interrupt_enable
	& transmit_flag);

always_ff @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		wake_req <= 1'b0;
		irq_req <= 1'b0;
	end else begin
		wake_req <= sleep_mode & int_src;
		irq_req <= global_interrupt_enable & int_src;
	end
end

a_wake_tx: assert property (sleep_mode && peripheral_interrupt_enable
	&& transmit_interrupt_enable && !thr_full |=> wake_req)
	else $error("transmit flag did not wake");
c_wake: cover property ($rose(wake_req));

// Register read
always_comb begin
	rd_val = REG_RST;
	case (addr)
		ADR_BAUD: begin
			rd_val[BIT_POL] = clock_polarity_select;
			rd_val[BIT_WIDE] = wide_divisor_select;
		end
		ADR_INTC: begin
			rd_val[BIT_GLOB_IE] = global_interrupt_enable;
			rd_val[BIT_PERI_IE] = peripheral_interrupt_enable;
		end
		ADR_PIE: begin
			rd_val[BIT_RX_IE] = receive_interrupt_enable;
			rd_val[BIT_TX_IE] = transmit_interrupt_enable;
		end
		ADR_PIR: begin
			rd_val[BIT_RX_FLAG] = receive_flag;
			rd_val[BIT_TX_FLAG] = transmit_flag;
		end
		ADR_RXD: rd_val = top_char[7:0];
		ADR_RCST: begin
			rd_val[BIT_PORT_EN] = serial_port_enable;
			rd_val[BIT_RX_NINE] = nine_bit_receive;
			rd_val[BIT_RX_ONE] = single_receive_enable;
			rd_val[BIT_RX_CONT] = continuous_receive_enable;
			rd_val[BIT_OVERRUN] = overrun_error;
			rd_val[BIT_RX_BIT8] = top_char[8];
		end
		ADR_DIVL: rd_val = divisor_low_byte;
		ADR_DIVH: rd_val = divisor_high_byte;
		ADR_TXST: begin
			rd_val[BIT_CLK_MST] = clock_source_master;
			rd_val[BIT_TX_NINE] = nine_bit_transmit;
			rd_val[BIT_TX_EN] = transmit_enable;
			rd_val[BIT_SYNC] = sync_mode;
			rd_val[BIT_HI_RATE] = high_rate_select;
			rd_val[BIT_TX_IDLE] = tx_state == TXS_IDLE;
			rd_val[BIT_TX_BIT8] = transmit_ninth_bit;
		end
		default: rd_val = REG_RST;
	endcase
end

always_ff @(posedge ref_clk or posedge rst) begin
	if (rst)
		rdata <= REG_RST;
	else
		rdata <= rd ? rd_val : REG_RST;
end

a_rx_flag_rd: assert property (rd && addr == ADR_PIR
	&& fifo_cnt != FIFO_EMPTY |=> rdata[BIT_RX_FLAG])
	else $error("receive flag not shown");

endmodule
`default_nettype wire

// File: ssm_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_partner (
	// Pin levels seen at the far side
	input wire logic ck_line,
	input wire logic dt_line,
	input wire logic pol,
	// Partner drive
	output logic p_ck,
	output logic p_dt
);
	logic [8:0] resp;
	logic resp_on;
	int ridx;

	initial begin
		p_ck = 1'b0;
		p_dt = 1'b0;
		resp = 9'h000;
		resp_on = 1'b0;
		ridx = 0;
	end

	// Clock master frame; clock stands still at idle level between frames
	task automatic frame(input int n, input logic [8:0] tx, input logic drv,
			output logic [8:0] rx);
		rx = 9'h000;
		#7;
		for (int i = 0; i < n; i++) begin
			p_ck = ~pol;
			if (drv)
				p_dt = tx[i];
			#160;
			p_ck = pol;
			// Sample well before the device's synced edge can move the line
			#40;
			rx[i] = dt_line;
			#120;
		end
		// Released line shows the inverse, never a stale copy
		p_dt = ~p_dt;
	endtask

	// Slave role in master reception: new bit on each rising edge of the clock line
	always @(posedge ck_line) begin
		if (resp_on) begin
			p_dt <= (ridx < 8) ? resp[ridx] : ~p_dt;
			ridx <= ridx + 1;
		end
	end
endmodule
`default_nettype wire

// File: tb_sync_serial_master_rx_slave_txrx.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sync_serial_master_rx_slave_txrx;
	import ssm_pkg::*;
	logic ref_clk, rst, wr, rd, sleep_mode, pol;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic wake_req, irq_req, ck_out, ck_oe_n, dt_out, dt_oe_n, p_ck, p_dt;
	wire logic ck_line = ck_oe_n ? p_ck : ck_out;
	wire logic dt_line = dt_oe_n ? p_dt : dt_out;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;

	ssm_port i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .sleep_mode(sleep_mode),
		.wake_req(wake_req), .irq_req(irq_req),
		.shift_clock_pin_in(ck_line), .shift_clock_pin_out(ck_out),
		.shift_clock_pin_oe_n(ck_oe_n), .serial_data_pin_in(dt_line),
		.serial_data_pin_out(dt_out), .serial_data_pin_oe_n(dt_oe_n));
	ssm_partner i_partner (.ck_line(ck_line), .dt_line(dt_line), .pol(pol),
		.p_ck(p_ck), .p_dt(p_dt));

	always #20 ref_clk = ~ref_clk;

	// Whole run needs roughly a thousand cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		reg_rd(a, d);
		chk_val({1'b0, d}, {1'b0, e});
	endtask

	task automatic t_regs();
		rd_chk(4'hF, 8'h00);
		reg_wr(ADR_BAUD, 8'hFF);
		rd_chk(ADR_BAUD, 8'h18);
		reg_wr(ADR_BAUD, 8'h00);
		reg_wr(ADR_PIE, 8'hFF);
		rd_chk(ADR_PIE, 8'h30);
		reg_wr(ADR_PIE, 8'h00);
	endtask

	task automatic t_slave_tx();
		logic [8:0] rx;
		reg_wr(ADR_RCST, 8'h80);
		reg_wr(ADR_TXST, 8'h10);
		reg_wr(ADR_PIE, 8'h10);
		reg_wr(ADR_INTC, 8'h40);
		reg_wr(ADR_TXD, 8'hA5);
		rd_chk(ADR_TXST, 8'h12);
		reg_wr(ADR_TXST, 8'h30);
		reg_wr(ADR_TXD, 8'h3C);
		sleep_mode <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk_val({8'h00, ck_oe_n}, 9'h001);
		chk_val({8'h00, dt_oe_n}, 9'h000);
		rd_chk(ADR_PIR, 8'h00);
		chk_val({8'h00, wake_req}, 9'h000);
		i_partner.frame(8, 9'h000, 1'b0, rx);
		chk_val(rx, 9'h0A5);
		repeat (8) @(posedge ref_clk);
		rd_chk(ADR_PIR, 8'h10);
		chk_val({7'h00, wake_req, irq_req}, 9'h002);
		reg_wr(ADR_INTC, 8'hC0);
		repeat (3) @(posedge ref_clk);
		chk_val({8'h00, irq_req}, 9'h001);
		i_partner.frame(8, 9'h000, 1'b0, rx);
		chk_val(rx, 9'h03C);
		sleep_mode <= 1'b0;
		reg_wr(ADR_INTC, 8'h00);
		reg_wr(ADR_PIE, 8'h00);
	endtask

	task automatic t_slave_rx();
		logic [8:0] rx;
		logic [7:0] d;
		reg_wr(ADR_RCST, 8'h90);
		reg_wr(ADR_PIE, 8'h20);
		reg_wr(ADR_INTC, 8'h80);
		sleep_mode <= 1'b1;
		i_partner.frame(8, 9'h011, 1'b1, rx);
		repeat (8) @(posedge ref_clk);
		chk_val({7'h00, wake_req, irq_req}, 9'h003);
		i_partner.frame(8, 9'h022, 1'b1, rx);
		i_partner.frame(8, 9'h033, 1'b1, rx);
		repeat (8) @(posedge ref_clk);
		rd_chk(ADR_RCST, 8'h92);
		rd_chk(ADR_PIR, 8'h30);
		rd_chk(ADR_RXD, 8'h11);
		rd_chk(ADR_RXD, 8'h22);
		reg_wr(ADR_RCST, 8'h80);
		rd_chk(ADR_RCST, 8'h80);
		// Single enable only: slave must still receive
		reg_wr(ADR_RCST, 8'hE0);
		i_partner.frame(9, 9'h1AB, 1'b1, rx);
		i_partner.frame(9, 9'h0CD, 1'b1, rx);
		repeat (8) @(posedge ref_clk);
		rd_chk(ADR_RCST, 8'hE1);
		rd_chk(ADR_RXD, 8'hAB);
		i_partner.frame(9, 9'h0EE, 1'b1, rx);
		i_partner.frame(9, 9'h1EE, 1'b1, rx);
		repeat (8) @(posedge ref_clk);
		rd_chk(ADR_RCST, 8'hE2);
		reg_wr(ADR_RCST, 8'h60);
		rd_chk(ADR_RCST, 8'h60);
		reg_rd(ADR_PIR, d);
		chk_val({8'h00, d[5]}, 9'h000);
		sleep_mode <= 1'b0;
		reg_wr(ADR_INTC, 8'h00);
		reg_wr(ADR_PIE, 8'h00);
	endtask

	task automatic t_pol_nine();
		logic [8:0] rx;
		reg_wr(ADR_BAUD, 8'h10);
		pol <= 1'b1;
		i_partner.p_ck <= 1'b1;
		reg_wr(ADR_RCST, 8'h80);
		reg_wr(ADR_TXST, 8'h71);
		reg_wr(ADR_TXD, 8'h5A);
		repeat (6) @(posedge ref_clk);
		i_partner.frame(9, 9'h000, 1'b0, rx);
		chk_val(rx, 9'h15A);
		reg_wr(ADR_BAUD, 8'h00);
		pol <= 1'b0;
		i_partner.p_ck <= 1'b0;
		reg_wr(ADR_RCST, 8'h00);
	endtask

	task automatic t_master_rx();
		logic [7:0] d;
		int n;
		reg_wr(ADR_DIVL, 8'h03);
		reg_wr(ADR_DIVH, 8'h00);
		reg_wr(ADR_TXST, 8'h90);
		reg_wr(ADR_RCST, 8'h80);
		i_partner.resp = 9'h0C3;
		i_partner.ridx = 0;
		i_partner.resp_on = 1'b1;
		sleep_mode <= 1'b1;
		reg_wr(ADR_RCST, 8'hA0);
		repeat (100) @(posedge ref_clk);
		chk_val(i_partner.ridx[8:0], 9'h000);
		sleep_mode <= 1'b0;
		n = 0;
		d = 8'hA0;
		while (d[5] && n < 100) begin
			reg_rd(ADR_RCST, d);
			n++;
		end
		repeat (40) @(posedge ref_clk);
		chk_val({8'h00, ck_oe_n}, 9'h000);
		chk_val(i_partner.ridx[8:0], 9'h008);
		rd_chk(ADR_RCST, 8'h80);
		rd_chk(ADR_RXD, 8'hC3);
		i_partner.resp_on = 1'b0;
	endtask

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		sleep_mode = 1'b0;
		pol = 1'b0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs();
		t_slave_tx();
		t_slave_rx();
		t_pol_nine();
		t_master_rx();
		stop_test();
	end
endmodule
`default_nettype wire
